// ===== ast_line_mon.sv
// Purpose: far-end receiver of the serial frames
// Assumes: fixed bit length in clocks
// Notes:   samples mid-bit; rx_word is the last word only
`timescale 1ns/1ps
`default_nettype none
module ast_line_mon #(
    parameter int BIT_LEN = 32
) (
    // Line
    input  wire logic       aclk,
    input  wire logic       tx_pin,
    input  wire logic       tx_pin_oe,
    input  wire logic       word9,
    // Result
    output logic [8:0]      rx_word,
    output logic            rx_stop,
    output int              rx_count
);
    int nb;
    initial begin
        rx_word = 9'h000;
        rx_stop = 1'b0;
        rx_count = 0;
        forever begin
            @(posedge aclk);
            if (tx_pin_oe && !tx_pin) begin
                nb = word9 ? 9 : 8;
                rx_word = 9'h000;
                repeat (BIT_LEN / 2) @(posedge aclk);
                for (int i = 0; i < nb; i++) begin
                    repeat (BIT_LEN) @(posedge aclk);
                    rx_word[i] = tx_pin;
                end
                repeat (BIT_LEN) @(posedge aclk);
                rx_stop = tx_pin;
                rx_count++;
            end
        end
    end
endmodule
`default_nettype wire

// ===== ast_pkg.sv
// Purpose: types of the serial transmitter
// Assumes: nothing
// Notes:   imported by no file; used by scope
package ast_pkg;

    typedef enum logic [2:0] {
        AST_OFF,
        AST_IDLE,
        AST_START,
        AST_DATA,
        AST_STOP,
        AST_MARK
    } ast_state_t;

    typedef struct packed {
        logic        awvalid;
        logic [3:0]  awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [3:0]  araddr;
        logic        rready;
    } ast_axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } ast_axi_rsp_t;

    typedef struct packed {
        // bus slave
        logic        aw_got;
        logic [3:0]  aw_addr;
        logic        w_got;
        logic [31:0] w_data;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        // software state
        logic [5:0]  ctrl;
        logic [4:0]  baud;
        logic        armed;
        logic        empty;
        logic        done;
        logic [8:0]  buffer;
        // link
        ast_state_t  state;
        logic [8:0]  shift;
        logic [3:0]  bitn;
        logic        brk;
        logic        en_seen;
        logic        reload;
        logic [15:0] tick_cnt;
        logic        pin;
        logic        pin_oe;
    } ast_state_s_t;

endpackage

// ===== ast_regs.svh
// Purpose: register offsets, fields and reset values of the serial transmitter
// Assumes: AXI4-Lite with 32-bit data, one aligned word per register
// Notes:   definitions only
`ifndef AST_REGS_SVH
`define AST_REGS_SVH

// ****************************************
// Offsets
// ****************************************
`define AST_OFF_STATUS    4'h0
`define AST_OFF_DATA      4'h4
`define AST_OFF_CTRL      4'h8
`define AST_OFF_BAUD      4'hC

// ****************************************
// Fields
// ****************************************
`define AST_ST_EMPTY      7
`define AST_ST_DONE       6
`define AST_CT_NINTH      0
`define AST_CT_WORD9      1
`define AST_CT_ENABLE     2
`define AST_CT_BREAK      3
`define AST_CT_EMPTY_IE   4
`define AST_CT_DONE_IE    5
`define AST_BAUD_OVERSAMP 32

// ****************************************
// Reset values
// ****************************************
`define AST_STATUS_RST    8'hC0
`define AST_CTRL_RST      6'h00
`define AST_BAUD_RST      5'h00

`endif

// ===== ast_tx.sv
// Purpose: transmit side of an asynchronous NRZ serial port, AXI4-Lite slave
// Assumes: single clock aclk at 40 MHz, synchronous active-low reset
// Notes:   this module drives gpio_out onto tx_pin when tx_pin_oe is low
//
// Behaviour
// RULE1 - Transmitter off returns the pin to its port function.
// RULE2 - Enabled with nothing to send, the pin stays high.
// RULE3 - Frame: start bit, 8 or 9 data bits LSB first, stop bit.
// RULE4 - Word length select high sends nine bits, ninth from ninth_tx_bit.
// RULE5 - Start bit drives the pin low; for a nine-bit word 0x1FF the code holds it high after at most one clock.
// RULE6 - Stop bit drives the pin high.
// RULE7 - Idle character is a full all-ones frame before next data frame.
// RULE8 - Break is whole frames of zeros followed by one extra high bit.
// RULE9 - Transmit has its own baud generator, independent of the receiver.
// RULE10 - Setting tx_enable takes the pin and sends an idle frame first.
// RULE11 - Buffer empty clears only on status access then data write.
// RULE12 - Buffer empty sets when buffer moves to shifter as transfer begins.
// RULE13 - Interrupt request while buffer empty and its enable are set.
// RULE14 - Data write during transmission goes to buffer, copied at frame end.
// RULE15 - Data write when idle loads shifter, starts, sets buffer empty now.
// RULE16 - Complete flag sets at frame end; interrupt if its enable set.
// RULE17 - Break frames repeat while send_break; one high bit after clearing.
// RULE18 - Toggling tx_enable mid-frame sends idle next; buffered data lost.
// RULE19 - Complete flag clears by the same status access then data write.
// RULE20 - Baud rate is clock over 32 times prescaler times power-of-two.
// RULE21 - Each bit lasts exactly one transmit baud period.
//
// The AXI4-Lite register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "ast_regs.svh"

module ast_tx (
    // Clock and reset
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    // Register bus
    input  wire ast_pkg::ast_axi_req_t axi_req,
    output var  ast_pkg::ast_axi_rsp_t axi_rsp,
    // Serial pin
    input  wire logic                 gpio_out,
    output logic                      tx_pin,
    output logic                      tx_pin_oe,
    // Interrupt request to the core
    output logic                      tx_irq
);

    ast_pkg::ast_state_s_t s_q;
    ast_pkg::ast_state_s_t s_d;

    // ****************************************
    // Baud divider
    // ****************************************
    // Prescaler codes 0..3 give 1, 3, 4, 13
    function automatic logic [15:0] baud_period(input logic [4:0] b);
        logic [15:0] pre;
        pre = 16'h0001;
        case (b[1:0])
            2'h0:    pre = 16'h0001;
            2'h1:    pre = 16'h0003;
            2'h2:    pre = 16'h0004;
            default: pre = 16'h000D;
        endcase
        baud_period = 16'((pre * 16'(`AST_BAUD_OVERSAMP)) << b[4:2]);
    endfunction

    function automatic logic [31:0] pad8(input logic [7:0] v);
        pad8 = {24'h000000, v};
    endfunction

    logic tick;
    logic aw_take;
    logic w_take;
    logic ar_take;
    logic wr_fire;
    logic [7:0] status_v;
    logic data_wr;
    logic frame_end;
    logic [8:0] wr_word;

    // Period of 32 x 1 x 1 = 1.25 Mbaud at 40 MHz; above the nominal ceiling by design choice
    assign tick = (s_q.tick_cnt == 16'h0000);                      // see RULE20 see RULE9

    assign aw_take = axi_req.awvalid && !s_q.aw_got && !s_q.bvalid;
    assign w_take  = axi_req.wvalid && !s_q.w_got && !s_q.bvalid;
    assign ar_take = axi_req.arvalid && !s_q.rvalid;
    assign wr_fire = (s_q.aw_got || aw_take) && (s_q.w_got || w_take);
    assign status_v = {s_q.empty, s_q.done, 6'h00};

    always_comb begin
        logic [3:0]  wa;
        logic [31:0] wd;
        wa = s_q.aw_got ? s_q.aw_addr : axi_req.awaddr;
        wd = s_q.w_got ? s_q.w_data : axi_req.wdata;
        s_d = s_q;
        data_wr = 1'b0;
        frame_end = 1'b0;
        wr_word = 9'h000;

        // ****************************************
        // AXI4-Lite slave
        // ****************************************
        if (aw_take) begin
            s_d.aw_got = 1'b1;
            s_d.aw_addr = axi_req.awaddr;
        end
        if (w_take) begin
            s_d.w_got = 1'b1;
            s_d.w_data = axi_req.wdata;
        end
        if (s_q.bvalid && axi_req.bready) begin
            s_d.bvalid = 1'b0;
        end
        if (s_q.rvalid && axi_req.rready) begin
            s_d.rvalid = 1'b0;
        end
        if (wr_fire) begin
            s_d.aw_got = 1'b0;
            s_d.w_got = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = 2'h0;
            case (wa)
                `AST_OFF_STATUS: s_d.armed = 1'b1;
                `AST_OFF_DATA: begin
                    if (axi_req.wstrb[0] || s_q.w_got) begin
                        data_wr = 1'b1;
                    end
                end
                `AST_OFF_CTRL: begin
                    if (axi_req.wstrb[0] || s_q.w_got) begin
                        s_d.ctrl = wd[5:0];
                    end
                end
                `AST_OFF_BAUD: begin
                    if (axi_req.wstrb[0] || s_q.w_got) begin
                        s_d.baud = wd[4:0];
                    end
                end
                default: s_d.bresp = 2'h2;
            endcase
        end
        if (ar_take) begin
            s_d.rvalid = 1'b1;
            s_d.rresp = 2'h0;
            case (axi_req.araddr)
                `AST_OFF_STATUS: begin
                    s_d.rdata = pad8(status_v);
                    s_d.armed = 1'b1;
                end
                `AST_OFF_DATA:  s_d.rdata = {23'h000000, s_q.buffer};
                `AST_OFF_CTRL:  s_d.rdata = {26'h0000000, s_q.ctrl};
                `AST_OFF_BAUD:  s_d.rdata = {27'h0000000, s_q.baud};
                default: begin
                    s_d.rdata = 32'h00000000;
                    s_d.rresp = 2'h2;
                end
            endcase
        end

        // ****************************************
        // Data write and flag clearing
        // ****************************************
        wr_word = {s_d.ctrl[`AST_CT_WORD9] & s_d.ctrl[`AST_CT_NINTH], wd[7:0]}; // see RULE4
        if (data_wr && s_q.armed) begin
            s_d.empty = 1'b0;                                      // see RULE11
            s_d.done = 1'b0;                                       // see RULE19
            s_d.armed = ar_take && (axi_req.araddr == `AST_OFF_STATUS);
        end
        if (data_wr) begin
            s_d.buffer = wr_word;
        end

        // ****************************************
        // Baud divider
        // ****************************************
        if (tick || s_q.state == ast_pkg::AST_OFF) begin
            s_d.tick_cnt = 16'(baud_period(s_q.baud) - 16'h0001);  // see RULE21
        end else begin
            s_d.tick_cnt = 16'(s_q.tick_cnt - 16'h0001);
        end

        // Enable drop while busy queues an idle frame and drops the buffer
        if (!s_q.ctrl[`AST_CT_ENABLE] && s_q.state != ast_pkg::AST_OFF) begin
            s_d.en_seen = 1'b1;                                    // see RULE18
        end

        // ****************************************
        // Transmit sequencer
        // ****************************************
        case (s_q.state)
            ast_pkg::AST_OFF: begin
                s_d.pin_oe = 1'b0;                                 // see RULE1
                s_d.pin = 1'b1;
                s_d.en_seen = 1'b0;
                if (s_q.ctrl[`AST_CT_ENABLE]) begin
                    s_d.state = ast_pkg::AST_START;                // see RULE10
                    s_d.brk = 1'b0;
                    s_d.shift = 9'h1FF;                            // see RULE7
                    s_d.bitn = 4'h0;
                    s_d.reload = 1'b0;
                    s_d.pin_oe = 1'b1;
                end
            end
            ast_pkg::AST_IDLE: begin
                s_d.pin = 1'b1;                                    // see RULE2
                if (!s_q.ctrl[`AST_CT_ENABLE]) begin
                    s_d.state = ast_pkg::AST_OFF;
                // Start bit goes low at the edge that enters the start state
                end else if (s_q.ctrl[`AST_CT_BREAK]) begin
                    s_d.state = ast_pkg::AST_START;                // see RULE17
                    s_d.brk = 1'b1;
                    s_d.shift = 9'h000;
                    s_d.pin = 1'b0;
                    s_d.reload = s_q.reload || data_wr;
                end else if (data_wr) begin
                    s_d.state = ast_pkg::AST_START;                // see RULE15
                    s_d.brk = 1'b0;
                    s_d.shift = wr_word;
                    s_d.empty = 1'b1;
                    s_d.reload = 1'b0;
                    s_d.pin = 1'b0;                                // see RULE5
                end else if (s_q.reload) begin
                    // Word left waiting behind a break
                    s_d.state = ast_pkg::AST_START;                // see RULE14
                    s_d.brk = 1'b0;
                    s_d.shift = s_q.buffer;
                    s_d.reload = 1'b0;
                    s_d.empty = 1'b1;
                    s_d.pin = 1'b0;
                end
                s_d.tick_cnt = 16'(baud_period(s_q.baud) - 16'h0001);
            end
            ast_pkg::AST_START: begin
                s_d.pin = (s_q.shift == 9'h1FF && !s_q.brk) ? 1'b1 : 1'b0; // see RULE5
                // Writes during a break frame wait in the buffer too
                if (data_wr) begin
                    s_d.reload = 1'b1;                             // see RULE14
                end
                if (tick) begin
                    s_d.state = ast_pkg::AST_DATA;
                    s_d.bitn = 4'h0;
                    s_d.pin = s_q.shift[0];                        // see RULE3
                end
            end
            ast_pkg::AST_DATA: begin
                if (data_wr) begin
                    s_d.reload = 1'b1;
                end
                if (tick) begin
                    s_d.bitn = 4'(s_q.bitn + 4'h1);
                    s_d.shift = {1'b0, s_q.shift[8:1]} | (s_q.shift == 9'h1FF ? 9'h100 : 9'h000);
                    if (s_q.bitn == (s_q.ctrl[`AST_CT_WORD9] ? 4'h8 : 4'h7)) begin
                        s_d.state = ast_pkg::AST_STOP;
                        s_d.pin = ~s_q.brk;                        // see RULE6 see RULE8
                    end else begin
                        s_d.pin = s_q.shift[1];
                    end
                end
            end
            ast_pkg::AST_STOP: begin
                if (data_wr) begin
                    s_d.reload = 1'b1;
                end
                if (tick) begin
                    frame_end = 1'b1;
                    s_d.done = 1'b1;                               // see RULE16
                    s_d.state = ast_pkg::AST_IDLE;
                    if (!s_q.ctrl[`AST_CT_ENABLE]) begin
                        s_d.state = ast_pkg::AST_OFF;
                    end else if (s_q.en_seen) begin
                        s_d.state = ast_pkg::AST_START;
                        s_d.shift = 9'h1FF;
                        s_d.brk = 1'b0;
                        s_d.reload = 1'b0;
                        s_d.en_seen = 1'b0;
                        s_d.empty = 1'b1;
                    end else if (s_q.ctrl[`AST_CT_BREAK]) begin
                        s_d.state = ast_pkg::AST_START;
                        s_d.brk = 1'b1;
                        s_d.shift = 9'h000;
                    end else if (s_q.brk) begin
                        s_d.state = ast_pkg::AST_MARK;             // see RULE8
                        s_d.pin = 1'b1;
                    end else if (s_q.reload || data_wr) begin
                        s_d.state = ast_pkg::AST_START;            // see RULE14
                        s_d.shift = data_wr ? wr_word : s_q.buffer;
                        s_d.reload = 1'b0;
                        s_d.empty = 1'b1;                          // see RULE12
                    end
                    s_d.pin = s_d.state == ast_pkg::AST_START ? 1'b0 : 1'b1;
                    if (s_d.state == ast_pkg::AST_START && s_d.shift == 9'h1FF && !s_d.brk) begin
                        s_d.pin = 1'b1;
                    end
                end
            end
            ast_pkg::AST_MARK: begin
                s_d.pin = 1'b1;
                if (data_wr) begin
                    s_d.reload = 1'b1;
                end
                if (tick) begin
                    s_d.state = ast_pkg::AST_IDLE;
                    s_d.brk = 1'b0;
                end
            end
            default: s_d.state = ast_pkg::AST_OFF;
        endcase
        // Set wins over a clearing write in the same cycle
        if (frame_end) begin
            s_d.done = 1'b1;                                       // see RULE16
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
            s_q.empty <= 1'(`AST_STATUS_RST >> `AST_ST_EMPTY);
            s_q.done <= 1'(`AST_STATUS_RST >> `AST_ST_DONE);
            s_q.ctrl <= `AST_CTRL_RST;
            s_q.baud <= `AST_BAUD_RST;
            s_q.state <= ast_pkg::AST_OFF;
            s_q.pin <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign axi_rsp.awready = !s_q.aw_got && !s_q.bvalid;
    assign axi_rsp.wready  = !s_q.w_got && !s_q.bvalid;
    assign axi_rsp.bvalid  = s_q.bvalid;
    assign axi_rsp.bresp   = s_q.bresp;
    assign axi_rsp.arready = !s_q.rvalid;
    assign axi_rsp.rvalid  = s_q.rvalid;
    assign axi_rsp.rdata   = s_q.rdata;
    assign axi_rsp.rresp   = s_q.rresp;
    assign tx_pin    = s_q.pin_oe ? s_q.pin : gpio_out;            // see RULE1
    assign tx_pin_oe = s_q.pin_oe;
    assign tx_irq = (s_q.empty && s_q.ctrl[`AST_CT_EMPTY_IE])      // see RULE13
                  || (s_q.done && s_q.ctrl[`AST_CT_DONE_IE]);      // see RULE16

endmodule
`default_nettype wire

// ===== ast_tx_chk.sv
// Purpose: port checks of the serial transmitter
// Assumes: one clock, synchronous active-low reset
// Notes:   bound from the bench top file
`timescale 1ns/1ps
`default_nettype none
module ast_tx_chk (
    // Clock and reset
    input wire logic                  aclk,
    input wire logic                  aresetn,
    // Register bus
    input wire ast_pkg::ast_axi_req_t axi_req,
    input wire ast_pkg::ast_axi_rsp_t axi_rsp,
    // Serial pin
    input wire logic                  gpio_out,
    input wire logic                  tx_pin,
    input wire logic                  tx_pin_oe,
    input wire logic                  tx_irq
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Low run length; every bit period is a whole multiple of 32 clocks
    logic [15:0] low_q;
    always_ff @(posedge aclk) begin
        if (!aresetn || !tx_pin_oe || tx_pin) begin
            low_q <= 16'h0000;
        end else begin
            low_q <= low_q + 16'h0001;
        end
    end

    sequence s_wr_take;
        axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
    endsequence
    sequence s_rd_take;
        axi_req.arvalid && axi_rsp.arready;
    endsequence

    a_off_gpio: assert property (
        !tx_pin_oe |-> tx_pin == gpio_out) else $error("pin not on port function");
    a_reset_quiet: assert property (
        $rose(aresetn) |-> !tx_pin_oe && !tx_irq) else $error("pin or irq busy after reset");
    a_enable_idle: assert property (
        $rose(tx_pin_oe) |-> tx_pin [*8]) else $error("no idle frame on enable");
    a_low_whole: assert property (
        $rose(tx_pin) && tx_pin_oe && $past(tx_pin_oe)
        |-> low_q != 16'h0000 && low_q[4:0] == 5'h00) else $error("low run not whole bits");
    a_write_answer: assert property (
        s_wr_take |=> axi_rsp.bvalid) else $error("write response late");
    a_read_answer: assert property (
        s_rd_take |=> axi_rsp.rvalid) else $error("read response late");
    a_r_hold: assert property (
        axi_rsp.rvalid && !axi_req.rready |=> axi_rsp.rvalid && $stable(axi_rsp.rdata))
        else $error("read data dropped");
    a_ar_busy: assert property (
        axi_rsp.rvalid |-> !axi_rsp.arready) else $error("read taken while busy");
endmodule
`default_nettype wire

// ===== ast_tx_tb.sv
// Purpose: register-level test of the serial transmitter
// Assumes: baud register at its fastest, 32 clocks a bit, until the last scenario
// Notes:   frames judged by the line monitor
`timescale 1ns/1ps
`default_nettype none
module ast_tx_tb;
    localparam int BIT = 32;
    logic                  aclk;
    logic                  aresetn;
    logic                  gpio_out;
    logic                  word9;
    ast_pkg::ast_axi_req_t req;
    ast_pkg::ast_axi_rsp_t rsp;
    logic                  tx_pin;
    logic                  tx_pin_oe;
    logic                  tx_irq;
    logic [8:0]            rx_word;
    logic                  rx_stop;
    int                    rx_count;
    int                    num_errors;
    int                    check_count;
    int                    base;
    int                    lowlen;
    logic [31:0]           rd;
    logic [1:0]            rr;

    ast_tx DUT (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
        .gpio_out(gpio_out), .tx_pin(tx_pin), .tx_pin_oe(tx_pin_oe), .tx_irq(tx_irq));
    ast_line_mon #(.BIT_LEN(BIT)) u_mon (.aclk(aclk), .tx_pin(tx_pin),
        .tx_pin_oe(tx_pin_oe), .word9(word9), .rx_word(rx_word), .rx_stop(rx_stop),
        .rx_count(rx_count));

    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end

    task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask

    task give_verdict;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Both halves offered together, each dropped when taken
    task wr(input logic [3:0] a, input logic [31:0] d);
        logic aw;
        logic w;
        aw = 1'b0;
        w = 1'b0;
        req.awaddr <= a;
        req.wdata <= d;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        while (!(aw && w)) begin
            @(posedge aclk);
            if (req.awvalid && rsp.awready) begin
                aw = 1'b1;
                req.awvalid <= 1'b0;
            end
            if (req.wvalid && rsp.wready) begin
                w = 1'b1;
                req.wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (rsp.bvalid !== 1'b1);
    endtask

    // Ready raised late on purpose so the held answer is exercised
    task rdr(input logic [3:0] a);
        req.araddr <= a;
        req.arvalid <= 1'b1;
        do @(posedge aclk); while (rsp.arready !== 1'b1);
        req.arvalid <= 1'b0;
        do @(posedge aclk); while (rsp.rvalid !== 1'b1);
        req.rready <= 1'b1;
        @(posedge aclk);
        rd = rsp.rdata;
        rr = rsp.rresp;
        req.rready <= 1'b0;
    endtask

    task st(input logic [1:0] e);
        rdr(4'h0);
        chk("status", {30'h0, rd[7:6]}, {30'h0, e});
    endtask

    task wait_rx(input int n);
        int k;
        k = 0;
        while (rx_count < n && k < 4000) begin
            @(posedge aclk);
            k++;
        end
        chk("frames", rx_count, n);
    endtask

    initial begin
        #(25 * 20000);
        num_errors++;
        $display("unexpected watchdog: expected done seen hang");
        give_verdict;
    end

    initial begin
        aresetn = 1'b0;
        gpio_out = 1'b0;
        word9 = 1'b0;
        req = '0;
        req.wstrb = 4'hF;
        req.bready = 1'b1;
        num_errors = 0;
        check_count = 0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk("oe", tx_pin_oe, 0);
        chk("pin", tx_pin, gpio_out);
        st(2'b11);
        chk("irq", tx_irq, 0);
        rdr(4'h8);
        chk("ctrl", rd[5:0], 0);
        rdr(4'hC);
        chk("baud", rd[4:0], 0);
        rdr(4'h2);
        chk("unmapped", rr, 2);
        wr(4'h8, 32'h0000_0034);
        @(posedge aclk);
        chk("oe", tx_pin_oe, 1);
        chk("irq", tx_irq, 1);
        base = rx_count;
        repeat (12 * BIT) @(posedge aclk);
        chk("idle frames", rx_count, base);
        chk("idle pin", tx_pin, 1);
        rdr(4'h0);
        wr(4'h4, 32'h0000_00A5);
        st(2'b10);
        wr(4'h4, 32'h0000_003C);
        st(2'b00);
        chk("irq", tx_irq, 0);
        wait_rx(base + 1);
        chk("word", rx_word, 9'h0A5);
        chk("stop", rx_stop, 1);
        repeat (BIT) @(posedge aclk);
        st(2'b11);
        wait_rx(base + 2);
        chk("word", rx_word, 9'h03C);
        repeat (BIT) @(posedge aclk);
        st(2'b11);
        chk("irq", tx_irq, 1);
        rdr(4'h0);
        wr(4'h4, 32'h0000_005A);
        wr(4'h4, 32'h0000_0066);
        wr(4'h8, 32'h0000_0030);
        wr(4'h8, 32'h0000_0034);
        wait_rx(base + 3);
        chk("word", rx_word, 9'h05A);
        repeat (24 * BIT) @(posedge aclk);
        chk("dropped", rx_count, base + 3);
        word9 <= 1'b1;
        wr(4'h8, 32'h0000_0037);
        rdr(4'h0);
        wr(4'h4, 32'h0000_0055);
        wait_rx(base + 4);
        chk("word9", rx_word, 9'h155);
        repeat (2 * BIT) @(posedge aclk);
        word9 <= 1'b0;
        wr(4'h8, 32'h0000_003C);
        wait_rx(base + 5);
        chk("break word", rx_word, 0);
        chk("break stop", rx_stop, 0);
        repeat (20 * BIT) @(posedge aclk);
        chk("break held", tx_pin, 0);
        wr(4'h8, 32'h0000_0034);
        repeat (12 * BIT) @(posedge aclk);
        chk("mark bit", tx_pin, 1);
        st(2'b11);
        wr(4'hC, 32'h0000_0001);
        wr(4'h4, 32'h0000_00FF);
        lowlen = 0;
        while (tx_pin === 1'b0 && lowlen < 1000) begin
            @(posedge aclk);
            lowlen++;
        end
        chk("start len", lowlen, 3 * BIT);
        repeat (30 * BIT) @(posedge aclk);
        wr(4'h8, 32'h0000_0030);
        repeat (12 * BIT) @(posedge aclk);
        gpio_out <= 1'b1;
        repeat (2) @(posedge aclk);
        chk("oe off", tx_pin_oe, 0);
        chk("port pin", tx_pin, 1);
        give_verdict;
    end
endmodule

bind ast_tx ast_tx_chk u_chk (.aclk(aclk), .aresetn(aresetn), .axi_req(axi_req),
    .axi_rsp(axi_rsp), .gpio_out(gpio_out), .tx_pin(tx_pin), .tx_pin_oe(tx_pin_oe),
    .tx_irq(tx_irq));
`default_nettype wire
